/* File: hw/gpev_pkg.sv */
// constants for the general-purpose event and pin block
package gpev_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFF_EVENT_STATUS = 8'h88;
	localparam logic [7:0] OFF_EVENT_ENABLE = 8'h89;
	localparam logic [7:0] OFF_INPUT_LEVEL  = 8'h8a;
	localparam logic [7:0] OFF_OUTPUT_LEVEL = 8'h8b;
	localparam logic [7:0] OFF_PIN_SELECT   = 8'h8c;
	localparam logic [7:0] OFF_IRQ_STATUS   = 8'h90;
	localparam logic [7:0] OFF_IRQ_MASK     = 8'h94;
	localparam int unsigned BIT_POWER = 7;
	localparam int unsigned BIT_VPP   = 6;
	localparam logic [7:0] STATUS_MASK = 8'hdf;
	localparam logic [7:0] ENABLE_MASK = 8'hdf;
	localparam logic [7:0] LEVEL_MASK  = 8'h1f;
	localparam logic [7:0] RST_STATUS  = 8'h00;
	localparam logic [7:0] RST_ENABLE  = 8'h00;
	localparam logic [7:0] RST_OUTPUT  = 8'h00;
	localparam logic [19:0] RST_SELECT = 20'h00000;
	localparam logic [1:0] RST_IRQ     = 2'h0;
	localparam logic [3:0] SEL_INPUT   = 4'h0;
	localparam logic [3:0] SEL_OUTPUT  = 4'h1;
	localparam logic [3:0] SEL_EVENT   = 4'he;
endpackage

/* File: hw/gpev_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module gpev_sync #(
	parameter int unsigned WIDTH = 5
) (
	// clocking
	input  wire logic             clock,
	input  wire logic             clk_en,
	// data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_q;
	wire  [WIDTH-1:0] agree = ~(s2_q ^ s3_q);

	always_ff @(posedge clock) begin
		if (clk_en) begin
			s1_q  <= async_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= (agree & s3_q) | (~agree & out_q);
		end
	end

	assign sync_out = out_q;
endmodule // gpev_sync

/* File: hw/gpev_apb.sv */
// apb slave front end, zero wait state
`timescale 1ns/10ps
module gpev_apb (
	// apb
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [7:0] paddr,
	input  wire logic [7:0] rdata_sel,
	input  wire logic       mapped,
	output logic            wr_stb,
	output logic            rd_stb,
	output logic            slverr,
	output logic [31:0]     prdata_c
);
	wire access = psel & penable;
	assign wr_stb   = access & pwrite & mapped;
	assign rd_stb   = access & ~pwrite & mapped;
	// registered at setup so it stands with pready in the access cycle
	assign slverr   = psel & ~penable & ~mapped;
	assign prdata_c = {24'h000000, rdata_sel};
endmodule // gpev_apb

/* File: hw/gpev_top.sv */
// general-purpose event, input and output register block
// What this block does
// - power state change sets status bit seven
// - vpp to/from 12 V sets bit six
// - gpi level change sets bits four..zero
// - status/enable bit five read zero, ignore writes
// - level registers bits seven..five read zero
// - status and matching enable asserts event request
// - event request output is active low
// - input_level tracks gpi pins, read only
// - output_level drives gpo pins, reset zero
// - sticky bits cleared only by global reset
// - select code 0000 input, 0001 output
// - event request on pin only code 1110
//
// The APB register port was decided locally.
`timescale 1ns/10ps
module gpev_top (
	// clock and resets
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        global_reset_in,
	input  wire logic        clk_en,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// socket power triggers
	input  wire logic        power_state_write,
	input  wire logic        vpp_high_toggle,
	// multifunction pins 5,4,2,1,0
	input  wire logic [4:0]  multi_pin_in,
	output logic      [4:0]  multi_pin_out,
	output logic      [4:0]  multi_pin_oe,
	// events
	output logic             event_request_out_n,
	output logic             irq
);
	logic [7:0]  status_q;
	logic [7:0]  enable_q;
	logic [7:0]  output_q;
	logic [19:0] select_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_mask_q;
	logic [4:0]  level_prev_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic        pready_q;
	logic        evt_n_q;
	logic        irq_q;
	logic [4:0]  pin_out_q;
	logic [4:0]  pin_oe_q;
	logic [4:0]  level_s;
	logic        wr_stb;
	logic        rd_stb;
	logic        slverr_c;
	logic [31:0] prdata_c;

	function automatic logic [4:0] sel_match(input logic [19:0] sel, input logic [3:0] code);
		for (int i = 0; i < 5; i++) begin
			sel_match[i] = (sel[i*4 +: 4] == code);
		end
	endfunction

	gpev_sync #(.WIDTH(5)) u_sync (
		.clock    (clock),
		.clk_en   (clk_en),
		.async_in (multi_pin_in),
		.sync_out (level_s)
	);

	// register decode
	wire hit_status = paddr == gpev_pkg::OFF_EVENT_STATUS;
	wire hit_enable = paddr == gpev_pkg::OFF_EVENT_ENABLE;
	wire hit_input  = paddr == gpev_pkg::OFF_INPUT_LEVEL;
	wire hit_output = paddr == gpev_pkg::OFF_OUTPUT_LEVEL;
	wire hit_select = paddr == gpev_pkg::OFF_PIN_SELECT;
	wire hit_istat  = paddr == gpev_pkg::OFF_IRQ_STATUS;
	wire hit_imask  = paddr == gpev_pkg::OFF_IRQ_MASK;
	wire mapped = hit_status | hit_enable | hit_input | hit_output | hit_select
		| hit_istat | hit_imask;

	// pin modes
	wire [4:0] is_gpi = sel_match(select_q, gpev_pkg::SEL_INPUT);
	wire [4:0] is_gpo = sel_match(select_q, gpev_pkg::SEL_OUTPUT);
	wire [4:0] is_evt = sel_match(select_q, gpev_pkg::SEL_EVENT);

	wire [4:0] input_view = level_s & is_gpi;
	wire [7:0] input_reg  = {3'h0, input_view};
	wire [4:0] gpi_change = (level_s ^ level_prev_q) & is_gpi;
	wire [7:0] hw_set = {power_state_write, vpp_high_toggle, 1'b0, gpi_change};
	wire [7:0] sw_clr = (wr_stb & hit_status) ? pwdata[7:0] : 8'h00;
	wire [7:0] status_d = ((status_q & ~sw_clr) | hw_set) & gpev_pkg::STATUS_MASK;
	wire       evt_active = |(status_q & enable_q);
	wire [1:0] irq_set = {evt_active, |gpi_change};
	wire [1:0] irq_clr = (rd_stb & hit_istat) ? 2'h3 : 2'h0;
	wire [1:0] irq_d   = (irq_stat_q & ~irq_clr) | irq_set;

	wire [7:0] rsel =
		hit_status ? status_q :
		hit_enable ? enable_q :
		hit_input  ? input_reg :
		hit_output ? output_q :
		hit_select ? select_q[7:0] :
		hit_istat  ? {6'h00, irq_stat_q} :
		hit_imask  ? {6'h00, irq_mask_q} : 8'h00;

	gpev_apb u_apb (
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.rdata_sel (rsel),
		.mapped    (mapped),
		.wr_stb    (wr_stb),
		.rd_stb    (rd_stb),
		.slverr    (slverr_c),
		.prdata_c  (prdata_c)
	);

	// sticky registers: global reset only
	always_ff @(posedge clock) begin
		if (global_reset_in) begin
			status_q <= gpev_pkg::RST_STATUS;
			enable_q <= gpev_pkg::RST_ENABLE;
			output_q <= gpev_pkg::RST_OUTPUT;
			select_q <= gpev_pkg::RST_SELECT;
		end else if (clk_en) begin
			status_q <= status_d;
			if (wr_stb & hit_enable) begin
				enable_q <= pwdata[7:0] & gpev_pkg::ENABLE_MASK;
			end
			if (wr_stb & hit_output) begin
				output_q <= pwdata[7:0] & gpev_pkg::LEVEL_MASK;
			end
			if (wr_stb & hit_select) begin
				select_q <= pwdata[19:0];
			end
		end
	end

	// ordinary state
	always_ff @(posedge clock) begin
		if (sys_rst | global_reset_in) begin
			irq_stat_q   <= gpev_pkg::RST_IRQ;
			irq_mask_q   <= gpev_pkg::RST_IRQ;
			level_prev_q <= level_s; // no false edge after reset
			prdata_q     <= 32'h00000000;
			pslverr_q    <= 1'b0;
			pready_q     <= 1'b0;
			evt_n_q      <= 1'b1;
			irq_q        <= 1'b0;
			pin_out_q    <= 5'h00;
			pin_oe_q     <= 5'h00;
		end else if (clk_en) begin
			irq_stat_q   <= irq_d;
			if (wr_stb & hit_imask) begin
				irq_mask_q <= pwdata[1:0];
			end
			level_prev_q <= level_s;
			prdata_q     <= prdata_c;
			pslverr_q    <= slverr_c;
			pready_q     <= psel & ~penable;
			evt_n_q      <= ~evt_active;
			irq_q        <= |(irq_d & irq_mask_q);
			pin_out_q    <= (output_q[4:0] & is_gpo) | ({5{~evt_active}} & is_evt);
			pin_oe_q     <= is_gpo | is_evt;
		end
	end

	assign prdata              = prdata_q;
	assign pready              = pready_q;
	assign pslverr             = pslverr_q;
	assign event_request_out_n = evt_n_q;
	assign irq                 = irq_q;
	assign multi_pin_out       = pin_out_q;
	assign multi_pin_oe        = pin_oe_q;

	// checks
	property p_status_set;
		@(posedge clock) disable iff (sys_rst | global_reset_in)
		clk_en & power_state_write |=> status_q[7];
	endproperty
	a_status_set: assert property (p_status_set) else $error("power flag not set");
	property p_vpp_set;
		@(posedge clock) disable iff (sys_rst | global_reset_in)
		clk_en & vpp_high_toggle |=> status_q[6];
	endproperty
	a_vpp_set: assert property (p_vpp_set) else $error("vpp flag not set");
	property p_bit5;
		@(posedge clock) disable iff (global_reset_in)
		(status_q[5] == 1'b0) && (enable_q[5] == 1'b0);
	endproperty
	a_bit5: assert property (p_bit5) else $error("bit five set");
	property p_out_hi;
		@(posedge clock) disable iff (global_reset_in)
		output_q[7:5] == 3'h0;
	endproperty
	a_out_hi: assert property (p_out_hi) else $error("output high bits set");
	property p_evt;
		@(posedge clock) disable iff (sys_rst | global_reset_in)
		clk_en & (|(status_q & enable_q)) |=> !event_request_out_n;
	endproperty
	a_evt: assert property (p_evt) else $error("event request missing");
	property p_evt_idle;
		@(posedge clock) disable iff (sys_rst | global_reset_in)
		clk_en & ~(|(status_q & enable_q)) |=> event_request_out_n;
	endproperty
	a_evt_idle: assert property (p_evt_idle) else $error("spurious event request");
	property p_clear;
		@(posedge clock) disable iff (sys_rst | global_reset_in)
		clk_en & wr_stb & hit_status & pwdata[0] & ~gpi_change[0] |=> !status_q[0];
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");
	property p_keep;
		@(posedge clock) disable iff (global_reset_in)
		sys_rst |=> $stable(enable_q);
	endproperty
	a_keep: assert property (p_keep) else $error("enable lost on reset");
	property p_gpo;
		@(posedge clock) disable iff (sys_rst | global_reset_in)
		clk_en & is_gpo[0] |=> multi_pin_out[0] == $past(output_q[0]);
	endproperty
	a_gpo: assert property (p_gpo) else $error("gpo mismatch");
	property p_evt_pin;
		@(posedge clock) disable iff (sys_rst | global_reset_in)
		clk_en |=> ((multi_pin_out ^ {5{event_request_out_n}}) & $past(is_evt)) == 5'h00;
	endproperty
	a_evt_pin: assert property (p_evt_pin) else $error("event pin mismatch");
	property p_unmapped;
		@(posedge clock) disable iff (sys_rst | global_reset_in)
		clk_en & psel & ~penable & ~mapped |=> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");
endmodule // gpev_top

/* File: tb/gpev_pins.sv */
// board pin model for the general-purpose pins
`timescale 1ns/10ps
module gpev_pins (
	// board side levels
	input  wire logic [4:0] drive_lvl,
	// device pins
	input  wire logic [4:0] pin_out,
	input  wire logic [4:0] pin_oe,
	output logic      [4:0] pin_in
);
	// a driven pin reads back its own level
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : drive_lvl[i];
		end
	end
endmodule // gpev_pins

/* File: tb/tb_top.sv */
// self-checking bench for the event and pin register block
`timescale 1ns/10ps
module tb_top;
	localparam logic [7:0] ST = gpev_pkg::OFF_EVENT_STATUS;
	localparam logic [7:0] EN = gpev_pkg::OFF_EVENT_ENABLE;
	localparam logic [7:0] IL = gpev_pkg::OFF_INPUT_LEVEL;
	localparam logic [7:0] OL = gpev_pkg::OFF_OUTPUT_LEVEL;
	localparam logic [7:0] PS = gpev_pkg::OFF_PIN_SELECT;
	localparam logic [7:0] IM = gpev_pkg::OFF_IRQ_MASK;
	logic        clock = 1'h0, sys_rst = 1'h1, global_reset_in = 1'h1, clk_en = 1'h1;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        power_state_write = 1'h0, vpp_high_toggle = 1'h0, event_request_out_n, irq;
	logic [4:0]  drive_lvl = 5'h00, multi_pin_in, multi_pin_out, multi_pin_oe, prev;
	int          error_cnt = 0, checks_done = 0;
	always #25 clock = ~clock;
	gpev_top u_dut (.clock(clock), .sys_rst(sys_rst), .global_reset_in(global_reset_in),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.power_state_write(power_state_write), .vpp_high_toggle(vpp_high_toggle),
		.multi_pin_in(multi_pin_in), .multi_pin_out(multi_pin_out),
		.multi_pin_oe(multi_pin_oe), .event_request_out_n(event_request_out_n), .irq(irq));
	gpev_pins u_pins (.drive_lvl(drive_lvl), .pin_out(multi_pin_out), .pin_oe(multi_pin_oe),
		.pin_in(multi_pin_in));
	// one apb transfer, waits for pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do begin
			@(posedge clock);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic trig(input logic p, input logic v);
		@(posedge clock);
		power_state_write <= p;
		vpp_high_toggle <= v;
		@(posedge clock);
		power_state_write <= 1'h0;
		vpp_high_toggle <= 1'h0;
		repeat (3) @(posedge clock);
	endtask
	function automatic logic [31:0] lvl(input logic [7:0] v);
		return {24'h0, v & gpev_pkg::LEVEL_MASK};
	endfunction
	task automatic test_done;
		$display("checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		test_done;
	end
	initial begin
		void'($urandom(32'h8ed2));
		repeat (16) @(posedge clock);
		sys_rst <= 1'h0;
		global_reset_in <= 1'h0;
		rdchk(ST, 32'h0);
		rdchk(OL, 32'h0);
		apb(1'h0, 8'h80, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test 1 done");
		apb(1'h1, EN, 32'hff);
		rdchk(EN, 32'hdf);
		apb(1'h1, OL, 32'hff);
		rdchk(OL, lvl(8'hff));
		apb(1'h1, PS, 32'h1);
		repeat (2) @(posedge clock);
		chk({27'h0, multi_pin_oe & multi_pin_out}, 32'h1);
		apb(1'h1, EN, 32'h0);
		apb(1'h1, ST, 32'hff);
		rdchk(ST, 32'h0);
		$display("test 2 done");
		trig(1'h1, 1'h0);
		rdchk(ST, 32'h80);
		trig(1'h0, 1'h1);
		rdchk(ST, 32'hc0);
		chk({31'h0, event_request_out_n}, 32'h1);
		apb(1'h1, EN, 32'h40);
		repeat (2) @(posedge clock);
		chk({31'h0, event_request_out_n}, 32'h0);
		apb(1'h1, PS, 32'he1);
		repeat (2) @(posedge clock);
		chk({30'h0, multi_pin_oe[1], multi_pin_out[1]}, 32'h2);
		apb(1'h1, IM, 32'h3);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h1);
		apb(1'h1, IM, 32'h0);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
		apb(1'h1, ST, 32'h40);
		rdchk(ST, 32'h80);
		apb(1'h1, ST, 32'h0);
		rdchk(ST, 32'h80);
		chk({31'h0, event_request_out_n}, 32'h1);
		chk({31'h0, multi_pin_out[1]}, 32'h1);
		$display("test 3 done");
		@(posedge clock) sys_rst <= 1'h1;
		@(posedge clock) sys_rst <= 1'h0;
		rdchk(ST, 32'h80);
		rdchk(OL, 32'h1f);
		@(posedge clock) global_reset_in <= 1'h1;
		@(posedge clock) global_reset_in <= 1'h0;
		rdchk(ST, 32'h0);
		rdchk(OL, 32'h0);
		$display("test 4 done");
		for (int i = 0; i < 12; i++) begin
			apb(1'h1, PS, i[0] ? 32'h0 : 32'h2);
			repeat (8) @(posedge clock);
			apb(1'h1, ST, 32'hff);
			prev = drive_lvl;
			@(posedge clock) drive_lvl <= (i < 2) ? ~prev : 5'($urandom);
			repeat (8) @(posedge clock);
			rdchk(ST, {27'h0, (prev ^ drive_lvl) & (i[0] ? 5'h1f : 5'h1e)});
			apb(1'h0, IL, 32'h0);
			chk(rd, lvl({3'h0, drive_lvl & (i[0] ? 5'h1f : 5'h1e)}));
		end
		$display("test 5 done");
		test_done;
	end
endmodule // tb_top
